// file: src/acz_ctrl.sv
// Converter configuration, status, clock divider and zero-cross coefficient.
// Functional notes
// [R1] Zero-cross coefficient sets the detection lowpass; its top bit stays zero.
// [R2] Analog section powers off after conversion unless keep-powered bit 7 set.
// [R3] Conversion completion sets the done flag, bit 6.
// [R4] With interrupt enable bit 2 set, done flag requests a processor interrupt.
// [R5] Divider bits 5:4 give divide by 1, 2, 4; code 11 reserved.
// [R6] Busy bit 3 is high while one conversion runs, cleared at its end.
// [R7] Reference buffer enable bit 1 drives the reference output pin.
// [R8] Converter enable bit 0 keeps the converter hardware active.
// [R9] Supervisory software should not modify the configuration register.
// [R10] Reset sets enable, reference buffer and interrupt enable; rest cleared.
`timescale 1ns/1ps
module acz_ctrl #(
  parameter logic [15:0] RATE_RESET = acz_pkg::RATE_RST  // Rate reset value.
) (
  input wire logic mclk,                  // Master clock, 125 MHz.
  input wire logic rst_n,                 // Asynchronous reset, active low.
  input wire acz_pkg::acz_req_s req,      // Processor register request.
  output logic [15:0] rdata_r,            // Read data, valid next cycle.
  output logic rvalid_r,                  // Read data valid strobe.
  input wire logic conv_start,            // Converter starts a conversion.
  input wire logic conv_end,              // Converter finished a conversion.
  output logic conv_active_r,             // Converter hardware active.
  output logic analog_power_r,            // Analog section powered.
  output logic ref_buf_drive_r,           // Reference buffer to output pin.
  output logic conv_clk_tick_r,           // Converter clock strobe.
  output logic irq_r,                     // Conversion interrupt request.
  output logic [15:0] conv_rate_r,        // Conversion rate value.
  output logic [15:0] zc_coeff_r          // Zero-cross filter coefficient.
);

  acz_pkg::acz_cfg_s cfg_r;
  acz_pkg::acz_cfg_s cfg_nxt;
  acz_pkg::acz_state_e state_r;
  acz_pkg::acz_state_e state_nxt;
  logic [15:0] rate_nxt;
  logic [15:0] zc_nxt;
  logic [15:0] rdata_nxt;
  logic rvalid_nxt;
  logic conv_active_nxt;
  logic analog_power_nxt;
  logic ref_buf_drive_nxt;
  logic irq_nxt;
  logic tick;

  // Address match used by both the write and read paths.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  // ==========================================================================
  // Conversion sequence.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acz_pkg::ST_IDLE: begin
        if (conv_start && cfg_r.conv_en) begin
          state_nxt = acz_pkg::ST_CONV;
        end
      end
      acz_pkg::ST_CONV: begin
        if (conv_end || !cfg_r.conv_en) begin
          state_nxt = acz_pkg::ST_IDLE;
        end
      end
      default: state_nxt = acz_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Register writes and status updates.
  always_comb begin
    cfg_nxt = cfg_r;
    rate_nxt = conv_rate_r;
    zc_nxt = zc_coeff_r;
    if (req.wr) begin
      if (hit(req.addr, acz_pkg::CFG_OFS)) begin
        cfg_nxt.keep_powered = req.wdata[acz_pkg::KEEP_BIT];
        cfg_nxt.div = acz_pkg::acz_div_e'(
          req.wdata[acz_pkg::DIV_HI:acz_pkg::DIV_LO]);
        cfg_nxt.irq_en = req.wdata[acz_pkg::IE_BIT];
        cfg_nxt.ref_buf_en = req.wdata[acz_pkg::REFB_BIT];
        cfg_nxt.conv_en = req.wdata[acz_pkg::EN_BIT];
        if (!req.wdata[acz_pkg::DONE_BIT]) begin
          cfg_nxt.done = 1'b0;
        end
      end else if (hit(req.addr, acz_pkg::RATE_OFS)) begin
        rate_nxt = req.wdata;
      end else if (hit(req.addr, acz_pkg::ZC_OFS)) begin
        zc_nxt = req.wdata;
        zc_nxt[acz_pkg::ZC_MSB] = 1'b0; // [R1]
      end
    end
    cfg_nxt.busy = (state_nxt == acz_pkg::ST_CONV); // [R6]
    if (state_r == acz_pkg::ST_CONV && conv_end) begin
      cfg_nxt.done = 1'b1; // [R3]
    end
  end

  // ==========================================================================
  // Read path.
  always_comb begin
    rdata_nxt = acz_pkg::RDATA_RST;
    rvalid_nxt = req.rd;
    if (req.rd) begin
      if (hit(req.addr, acz_pkg::CFG_OFS)) begin
        rdata_nxt = {8'h00, cfg_r};
      end else if (hit(req.addr, acz_pkg::RATE_OFS)) begin
        rdata_nxt = conv_rate_r;
      end else if (hit(req.addr, acz_pkg::ZC_OFS)) begin
        rdata_nxt = zc_coeff_r;
      end
    end
  end

  // ==========================================================================
  // Converter side controls.
  always_comb begin
    conv_active_nxt = cfg_nxt.conv_en; // [R8]
    ref_buf_drive_nxt = cfg_nxt.ref_buf_en; // [R7]
    analog_power_nxt = cfg_nxt.conv_en &&
      (cfg_nxt.busy || cfg_nxt.keep_powered); // [R2]
    irq_nxt = cfg_nxt.done && cfg_nxt.irq_en; // [R4]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= acz_pkg::acz_cfg_s'(acz_pkg::CFG_RST); // [R10]
      state_r <= acz_pkg::ST_IDLE;
      conv_rate_r <= RATE_RESET;
      zc_coeff_r <= acz_pkg::ZC_RST;
      rdata_r <= acz_pkg::RDATA_RST;
      rvalid_r <= 1'b0;
      conv_active_r <= 1'b0;
      analog_power_r <= 1'b0;
      ref_buf_drive_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      state_r <= state_nxt;
      conv_rate_r <= rate_nxt;
      zc_coeff_r <= zc_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      conv_active_r <= conv_active_nxt;
      analog_power_r <= analog_power_nxt;
      ref_buf_drive_r <= ref_buf_drive_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================================
  // Converter clock strobe.
  acz_clk_div u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(cfg_r.conv_en),
    .div(cfg_r.div),
    .tick_r(tick)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_clk_tick_r <= 1'b0;
    end else begin
      conv_clk_tick_r <= tick; // [R5]
    end
  end

endmodule // acz_ctrl

// file: src/acz_pkg.sv
// Package with register map, field layout and types of the converter control.
package acz_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [11:0] CFG_OFS = 12'h004c;
  localparam logic [11:0] RATE_OFS = 12'h004e;
  localparam logic [11:0] ZC_OFS = 12'h005a;

  // ==========================================================================
  // Field positions of the converter configuration register and the coefficient top bit.
  localparam int KEEP_BIT = 7;
  localparam int DONE_BIT = 6;
  localparam int DIV_HI = 5;
  localparam int DIV_LO = 4;
  localparam int BUSY_BIT = 3;
  localparam int IE_BIT = 2;
  localparam int REFB_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int ZC_MSB = 15;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] CFG_RST = 8'h07;
  localparam logic [15:0] ZC_RST = 16'h0b00;
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // ==========================================================================
  // Clock divider codes and terminal counts.
  typedef enum logic [1:0] {
    DIV_BY1 = 2'b00,
    DIV_BY2 = 2'b01,
    DIV_BY4 = 2'b10,
    DIV_RSVD = 2'b11
  } acz_div_e;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] LAST_BY2 = 2'h1;
  localparam logic [1:0] LAST_BY4 = 2'h3;

  // ==========================================================================
  // Conversion state.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } acz_state_e;

  // Configuration fields as held in hardware.
  typedef struct packed {
    logic keep_powered;
    logic done;
    acz_div_e div;
    logic busy;
    logic irq_en;
    logic ref_buf_en;
    logic conv_en;
  } acz_cfg_s;

  // Processor register access request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } acz_req_s;

endpackage

// file: src/acz_clk_div.sv
// Converter clock strobe divided from the processor master clock.
`timescale 1ns/1ps
module acz_clk_div (
  input wire logic mclk,                  // Master clock.
  input wire logic rst_n,                 // Asynchronous reset, active low.
  input wire logic run,                   // Converter enabled.
  input wire acz_pkg::acz_div_e div,      // Division code.
  output logic tick_r                     // One-cycle converter clock strobe.
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic tick_nxt;
  logic [1:0] last;

  // ==========================================================================
  // Divider counter; the reserved code produces no strobe.
  always_comb begin
    last = acz_pkg::CNT_ZERO;
    tick_nxt = 1'b0;
    cnt_nxt = acz_pkg::CNT_ZERO;
    case (div)
      acz_pkg::DIV_BY2: last = acz_pkg::LAST_BY2;
      acz_pkg::DIV_BY4: last = acz_pkg::LAST_BY4;
      default: last = acz_pkg::CNT_ZERO;
    endcase
    if (run && div != acz_pkg::DIV_RSVD) begin // [R5]
      if (cnt_r >= last) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + acz_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= acz_pkg::CNT_ZERO;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

endmodule // acz_clk_div

// file: testbench/acz_conv_model.sv
// Behavioural converter, run by the bench, that drives the control block.
`timescale 1ns/1ps
module acz_conv_model #(
  parameter int LEN = 4
) (
  input wire logic mclk, // Clock.
  input wire logic go, // Run one conversion.
  output logic conv_start, // Start pulse.
  output logic conv_end // End pulse.
);
  initial begin
    conv_start = 1'b0;
    conv_end = 1'b0;
  end
  always @(posedge mclk) begin
    if (go) begin
      #1 conv_start = 1'b1;
      @(posedge mclk) #1 conv_start = 1'b0;
      repeat (LEN) @(posedge mclk);
      #1 conv_end = 1'b1;
      @(posedge mclk) #1 conv_end = 1'b0;
    end
  end
endmodule // acz_conv_model

// file: testbench/acz_ctrl_props.sv
// Port checks for the converter control block.
`timescale 1ns/1ps
module acz_ctrl_props (
  input wire logic mclk, // Clock.
  input wire logic rst_n, // Reset.
  input wire acz_pkg::acz_req_s req, // Request.
  input wire logic [15:0] rdata_r, // Read data.
  input wire logic rvalid_r, // Read valid.
  input wire logic conv_start, // Start.
  input wire logic conv_end, // End.
  input wire logic conv_active_r, // Active.
  input wire logic analog_power_r, // Power.
  input wire logic ref_buf_drive_r, // Ref buffer.
  input wire logic conv_clk_tick_r, // Strobe.
  input wire logic irq_r, // Interrupt.
  input wire logic [15:0] conv_rate_r, // Rate.
  input wire logic [15:0] zc_coeff_r // Coefficient.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic cw;
  assign cw = req.wr && req.addr == acz_pkg::CFG_OFS;
  property p_zc_msb; !zc_coeff_r[15]; endproperty
  a_zc_msb: assert property (p_zc_msb) else $error("zc msb");
  property p_zc_rd; req.rd && req.addr == acz_pkg::ZC_OFS |=>
    rvalid_r && rdata_r == $past(zc_coeff_r); endproperty
  a_zc_rd: assert property (p_zc_rd) else $error("zc read");
  property p_pwr; $rose(analog_power_r) |-> $past(conv_start) ||
    $past(conv_start, 2) || $past(cw) || $past(cw, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("power rise");
  property p_pwr_en; analog_power_r |->
    conv_active_r || $past(conv_active_r); endproperty
  a_pwr_en: assert property (p_pwr_en) else $error("power off");
  property p_irq; $rose(irq_r) |-> $past(conv_end) ||
    $past(conv_end, 2) || $past(cw) || $past(cw, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq cause");
  property p_ref; cw && req.wdata[1] |-> ##[1:2] ref_buf_drive_r;
  endproperty
  a_ref: assert property (p_ref) else $error("ref buffer");
  property p_en; cw && !req.wdata[0] |-> ##[1:2] !conv_active_r;
  endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_tick; !conv_active_r [*3] |-> !conv_clk_tick_r; endproperty
  a_tick: assert property (p_tick) else $error("strobe");
endmodule // acz_ctrl_props

// file: testbench/tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  acz_pkg::acz_req_s req = '0;
  logic [15:0] rdata_r, conv_rate_r, zc_coeff_r;
  logic rvalid_r, conv_start, conv_end, conv_active_r, analog_power_r;
  logic ref_buf_drive_r, conv_clk_tick_r, irq_r;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam logic [11:0] CFG = acz_pkg::CFG_OFS;
  always #4 mclk = ~mclk;
  acz_conv_model #(.LEN(4)) conv (.*);
  acz_ctrl dut (.*);
  task automatic results();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, s);
    chk(n, {15'h0000, e}, {15'h0000, s});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    req = '{1'b1, 1'b0, a, d};
    tick(1);
    req = '0;
    tick(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    req = '{1'b0, 1'b1, a, 16'h0000};
    tick(1);
    req = '0;
    chk1("rvalid", 1'b1, rvalid_r);
    chk("rdata", e, rdata_r);
    tick(1);
  endtask
  task automatic conv_run(input logic [15:0] mid, fin, input logic pw);
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(2);
    rd(CFG, mid);
    chk1("pwr busy", mid[3], analog_power_r);
    tick(8);
    rd(CFG, fin);
    chk1("pwr after", pw, analog_power_r);
  endtask
  task automatic t_reset();
    rd(CFG, 16'h0007);
    rd(acz_pkg::ZC_OFS, 16'h0b00);
    rd(12'h0050, 16'h0000);
    chk1("active", 1'b1, conv_active_r);
    chk1("refbuf", 1'b1, ref_buf_drive_r);
    wr(acz_pkg::ZC_OFS, 16'hffff);
    rd(acz_pkg::ZC_OFS, 16'h7fff);
    chk("zc port", 16'h7fff, zc_coeff_r);
    rd(acz_pkg::RATE_OFS, 16'h0000);
    wr(acz_pkg::RATE_OFS, 16'ha5c3);
    rd(acz_pkg::RATE_OFS, 16'ha5c3);
    chk("rate port", 16'ha5c3, conv_rate_r);
  endtask
  task automatic t_div();
    logic [15:0] n;
    for (int c = 0; c < 4; c++) begin
      wr(CFG, {8'h00, 2'b00, c[1:0], 4'h7});
      tick(3);
      n = 16'h0000;
      repeat (16) begin
        tick(1);
        n = n + {15'h0000, conv_clk_tick_r};
      end
      chk("ticks", (c == 3) ? 16'h0000 : 16'h0010 >> c, n);
    end
  endtask
  task automatic t_conv();
    wr(CFG, 16'h0007);
    conv_run(16'h000f, 16'h0047, 1'b0);
    chk1("irq", 1'b1, irq_r);
    wr(CFG, 16'h0083);
    tick(2);
    chk1("irq clr", 1'b0, irq_r);
    conv_run(16'h008b, 16'h00c3, 1'b1);
    chk1("irq off", 1'b0, irq_r);
    wr(CFG, 16'h0000);
    tick(2);
    chk1("active", 1'b0, conv_active_r);
    chk1("refbuf", 1'b0, ref_buf_drive_r);
    conv_run(16'h0000, 16'h0000, 1'b0);
  endtask
  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_div();
    t_conv();
    results();
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      results();
    end
  end
endmodule // tb
bind acz_ctrl acz_ctrl_props props (.*);
